// >>> logic/sac_pkg.sv
package sac_pkg;

  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [15:0] ADDR_RWORD_LO = 16'hFF08;
  localparam logic [15:0] ADDR_RWORD_HI = 16'hFF09;
  localparam logic [15:0] ADDR_RBYTE    = 16'hFF1F;
  localparam logic [15:0] ADDR_PORT_DIR = 16'hFF22;
  localparam logic [15:0] ADDR_MODE     = 16'hFF28;
  localparam logic [15:0] ADDR_CHAN     = 16'hFF29;
  localparam logic [15:0] ADDR_PFUNC    = 16'hFF2F;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0]  DIR_RST   = 8'hFF;
  localparam logic [3:0]  PFUNC_RST = 4'h0;
  localparam logic [2:0]  CHAN_RST  = 3'h0;
  localparam logic [4:0]  CTIME_RST = 5'h00;
  localparam logic [15:0] RWORD_RST = 16'h0000;
  localparam logic [7:0]  RBYTE_RST = 8'h00;

  // ==========================================================
  // Field layout
  // ==========================================================
  localparam int          MODE_CEN_BIT  = 0;
  localparam int          MODE_CT_LSB   = 1;
  localparam int          MODE_CT_MSB   = 5;
  localparam int          MODE_RUN_BIT  = 7;
  localparam logic [3:0]  PFUNC_ALL_DIG = 4'h8;
  localparam int          PIN_CNT       = 8;
  localparam logic [5:0]  RES_PAD       = 6'h00;
  localparam logic [9:0]  SAR_MSB_TRIAL = 10'h200;
  localparam logic [3:0]  SAR_TOP_IDX   = 4'h9;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int          CLK_NS        = 4;
  localparam int          SAMPLE_NS     = 80;
  localparam int          SAMPLE_CYC    = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [5:0]  SAMPLE_CNT    = 6'(SAMPLE_CYC);
  localparam logic [5:0]  STEP_BASE_CNT = 6'h04;

  typedef enum logic [1:0] {SAR_IDLE, SAR_SAMPLE, SAR_TEST} sac_sar_state_t;

endpackage

// >>> logic/sac_pin_decode.sv
`timescale 1ns/10ps
`default_nettype none
module sac_pin_decode import sac_pkg::*; (
  input  wire logic       core_clk_i,
  input  wire logic       srst_i,
  input  wire logic [3:0] pfunc_i,
  input  wire logic [7:0] dir_i,
  output logic      [7:0] analog_o,
  output logic      [7:0] oe_n_o
);

  typedef struct packed {
    logic [7:0] analog;
    logic [7:0] oe_n;
  } sac_dec_state_t;

  sac_dec_state_t s_r;
  sac_dec_state_t s_nxt;
  logic [7:0]     analog_w;
  logic [7:0]     oe_n_w;

  // ==========================================================
  // Per-pin decode
  // ==========================================================
  for (genvar g = 0; g < PIN_CNT; g++) begin : g_pin
    // (R1) lowest pins digital
    assign analog_w[g] = !((pfunc_i <= PFUNC_ALL_DIG) &&
                           (4'(g) < pfunc_i));
    // Analog pins never drive, which keeps the prohibited mix harmless.
    // (R5) direction to buffer
    assign oe_n_w[g] = analog_w[g] | dir_i[g];
  end

  always_comb begin
    s_nxt        = s_r;
    s_nxt.analog = analog_w;
    s_nxt.oe_n   = oe_n_w;
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      s_r <= '{analog: 8'hFF, oe_n: 8'hFF};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign analog_o = s_r.analog;
  assign oe_n_o   = s_r.oe_n;

  // (R8) analog never driven
  AST_ANALOG_NO_DRIVE: assert property (@(posedge core_clk_i)  // (R8)
    disable iff (srst_i) ((analog_o & ~oe_n_o) == 8'h00))
    else $error("Analog pin has its output buffer on.");
  // (R1) all digital code
  AST_ALL_DIGITAL: assert property (@(posedge core_clk_i)  // (R1)
    disable iff (srst_i) (pfunc_i == PFUNC_ALL_DIG) |=> (analog_o == 8'h00))
    else $error("Code eight left an analog pin.");

endmodule
`default_nettype wire

// >>> logic/sac_sar_core.sv
`timescale 1ns/10ps
`default_nettype none
module sac_sar_core import sac_pkg::*; (
  input  wire logic       core_clk_i,
  input  wire logic       srst_i,
  input  wire logic       run_i,
  input  wire logic       restart_i,
  input  wire logic [4:0] ctime_i,
  input  wire logic       cmp_i,
  output logic      [9:0] trial_o,
  output logic            sample_o,
  output logic            done_o,
  output logic      [9:0] result_o
);

  typedef struct packed {
    sac_sar_state_t state;
    logic [5:0]     cnt;
    logic [3:0]     idx;
    logic [9:0]     trial;
    logic           sample;
    logic           done;
    logic [9:0]     result;
  } sac_core_state_t;

  sac_core_state_t s_r;
  sac_core_state_t s_nxt;

  // ==========================================================
  // Approximation sequence
  // ==========================================================
  always_comb begin
    logic [9:0] dec;
    logic [5:0] step_len;
    logic [3:0] idx_m1;
    dec      = s_r.trial;
    // (R11) step time from field
    step_len = STEP_BASE_CNT + {3'h0, ctime_i[4:2]};
    idx_m1   = s_r.idx - 4'h1;
    s_nxt    = s_r;
    s_nxt.done = 1'b0;
    if (!run_i) begin
      // (R23) stop at once
      s_nxt.state  = SAR_IDLE;
      s_nxt.sample = 1'b0;
      s_nxt.cnt    = 6'h00;
    end else if (restart_i || s_r.state == SAR_IDLE) begin
      // (R17) restart from sampling
      s_nxt.state  = SAR_SAMPLE;
      s_nxt.sample = 1'b1;
      s_nxt.cnt    = SAMPLE_CNT;
    end else begin
      case (s_r.state)
        SAR_SAMPLE: begin
          if (s_r.cnt == 6'h01) begin
            // (R12) switch to hold
            s_nxt.state  = SAR_TEST;
            s_nxt.sample = 1'b0;
            // (R13) half scale first
            s_nxt.trial  = SAR_MSB_TRIAL;
            s_nxt.idx    = SAR_TOP_IDX;
            s_nxt.cnt    = step_len;
          end else begin
            s_nxt.cnt = s_r.cnt - 6'h01;
          end
        end
        SAR_TEST: begin
          if (s_r.cnt == 6'h01) begin
            // (R14) keep bit when input not below tap
            dec[s_r.idx] = cmp_i;
            if (s_r.idx == 4'h0) begin
              // (R16) convert again back to back
              s_nxt.result = dec;
              s_nxt.done   = 1'b1;
              s_nxt.state  = SAR_SAMPLE;
              s_nxt.sample = 1'b1;
              s_nxt.cnt    = SAMPLE_CNT;
              s_nxt.trial  = dec;
            end else begin
              dec[idx_m1] = 1'b1;
              s_nxt.idx   = idx_m1;
              s_nxt.trial = dec;
              s_nxt.cnt   = step_len;
            end
          end else begin
            s_nxt.cnt = s_r.cnt - 6'h01;
          end
        end
        default: begin
          s_nxt.state = SAR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      s_r <= '{state: SAR_IDLE, cnt: 6'h00, idx: 4'h0, trial: 10'h000,
               sample: 1'b0, done: 1'b0, result: 10'h000};
    end else begin
      s_r <= s_nxt;
    end
  end

  // (R24) tap is trial value
  assign trial_o  = s_r.trial;
  assign sample_o = s_r.sample;
  assign done_o   = s_r.done;
  assign result_o = s_r.result;

  AST_FIRST_TRIAL: assert property (@(posedge core_clk_i)  // (R13)
    disable iff (srst_i)
    (s_r.state == SAR_TEST && $past(s_r.state) == SAR_SAMPLE)
    |-> (trial_o == SAR_MSB_TRIAL && !sample_o))
    else $error("First trial is not half scale.");
  AST_HOLD_IN_TEST: assert property (@(posedge core_clk_i)  // (R12)
    disable iff (srst_i) (s_r.state == SAR_TEST) |-> !sample_o)
    else $error("Sampling while testing bits.");
  AST_STOP_NOW: assert property (@(posedge core_clk_i)  // (R23)
    disable iff (srst_i) !run_i |=> (s_r.state == SAR_IDLE && !sample_o))
    else $error("Conversion did not stop.");
  AST_ABORT_RESTART: assert property (@(posedge core_clk_i)  // (R17)
    disable iff (srst_i)
    (run_i && restart_i) |=> (sample_o && s_r.cnt == SAMPLE_CNT))
    else $error("Channel write did not restart sampling.");
  AST_REPEAT: assert property (@(posedge core_clk_i)  // (R16)
    disable iff (srst_i) done_o |-> (s_r.state == SAR_SAMPLE && sample_o))
    else $error("No new conversion after completion.");

endmodule
`default_nettype wire

// >>> logic/sac_adc_ctrl.sv
// Overview of operation
// (R1) Function code n makes lowest n pins digital; 0 all analog, 8 digital.
// (R2) Pin-function register reads upper nibble zero, resets to all analog.
// (R3) Writing pin-function register inserts a bus wait cycle.
// (R4) Small package: software avoids codes splitting the two missing pins.
// (R5) Direction bit 0 turns output buffer on, 1 makes pin input.
// (R6) Direction register resets to all ones, every pin input.
// (R7) Software keeps direction 1 on pins used as analog inputs.
// (R8) Pin role follows function and direction; analog output is prohibited.
// (R9) Enable bit powers comparator; run bit starts conversion.
// (R10) Software waits one microsecond between enable and run.
// (R11) Mode bits 5 to 1 select conversion time; step length uses only bits 5 to 3.
// (R12) Sample for a fixed time, then hold until conversion ends.
// (R13) First step tries bit 9 at half scale.
// (R14) Each step tries next bit; keep it when input not below tap.
// (R15) After ten bits copy result to both registers and pulse done.
// (R16) Conversions repeat back to back while run bit stays set.
// (R17) Channel write during conversion aborts and restarts from sampling.
// (R18) Word result holds ten bits; byte result holds top eight.
// (R19) Both result registers reset to zero.
// (R20) Software restarts with run bit, or changes channel by rewriting.
// (R21) Word result is left aligned; low six bits read zero.
// (R22) Channel selector is three bits picking one of eight inputs.
// (R23) Clearing run stops at once; results keep last value.
// (R24) Comparator decision is one input; tap is current trial value.
`timescale 1ns/10ps
`default_nettype none
module sac_adc_ctrl import sac_pkg::*; (
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  input  wire logic [15:0] cpu_addr_i,
  input  wire logic        cpu_wr_i,
  input  wire logic        cpu_rd_i,
  input  wire logic [7:0]  cpu_wdata_i,
  output logic      [7:0]  cpu_rdata_o,
  output logic             cpu_wait_o,
  input  wire logic        cmp_result_i,
  output logic             comparator_enable_o,
  output logic             sample_hold_o,
  output logic      [9:0]  tap_trial_o,
  output logic      [2:0]  channel_selector_o,
  output logic      [7:0]  analog_pin_en_o,
  output logic      [7:0]  pin_oe_n_o,
  output logic             conversion_done_irq_o
);

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic [7:0]  dir;
    logic [3:0]  pfunc;
    logic        cmp_en;
    logic [4:0]  ctime;
    logic        run;
    logic [2:0]  chan;
    logic [15:0] rword;
    logic [7:0]  rbyte;
    logic [7:0]  rdata;
    logic        bus_wait;
    logic        irq;
    logic        abort;
  } sac_top_state_t;

  sac_top_state_t s_r;
  sac_top_state_t s_nxt;
  logic           core_done;
  logic [9:0]     core_result;
  logic           wr_pfunc;
  logic           wr_chan;
  logic           rd_result;

  assign wr_pfunc  = cpu_wr_i && cpu_addr_i == ADDR_PFUNC;
  assign wr_chan   = cpu_wr_i && cpu_addr_i == ADDR_CHAN;
  assign rd_result = cpu_rd_i && (cpu_addr_i == ADDR_RWORD_LO ||
                                  cpu_addr_i == ADDR_RWORD_HI ||
                                  cpu_addr_i == ADDR_RBYTE);

  // ==========================================================
  // Register access and result capture
  // ==========================================================
  always_comb begin
    s_nxt       = s_r;
    s_nxt.irq   = 1'b0;
    s_nxt.abort = 1'b0;
    // (R3) wait on slow accesses
    s_nxt.bus_wait = wr_pfunc || wr_chan || rd_result;
    if (cpu_wr_i) begin
      case (cpu_addr_i)
        // (R5) direction register
        ADDR_PORT_DIR: s_nxt.dir = cpu_wdata_i;
        // (R1) function code stored
        ADDR_PFUNC: s_nxt.pfunc = cpu_wdata_i[3:0];
        ADDR_MODE: begin
          // (R9) enable and run bits
          s_nxt.cmp_en = cpu_wdata_i[MODE_CEN_BIT];
          s_nxt.run    = cpu_wdata_i[MODE_RUN_BIT];
          // (R11) conversion time field
          s_nxt.ctime  = cpu_wdata_i[MODE_CT_MSB:MODE_CT_LSB];
        end
        ADDR_CHAN: begin
          // (R22) three-bit channel
          s_nxt.chan  = cpu_wdata_i[2:0];
          // (R17) abort running conversion
          s_nxt.abort = s_r.run;
        end
        default: begin
          s_nxt.chan = s_r.chan;
        end
      endcase
    end
    if (cpu_rd_i) begin
      case (cpu_addr_i)
        ADDR_PORT_DIR: s_nxt.rdata = s_r.dir;
        // (R2) upper nibble reads zero
        ADDR_PFUNC:    s_nxt.rdata = {4'h0, s_r.pfunc};
        ADDR_MODE:     s_nxt.rdata = {s_r.run, 1'b0, s_r.ctime, s_r.cmp_en};
        ADDR_CHAN:     s_nxt.rdata = {5'h00, s_r.chan};
        ADDR_RWORD_LO: s_nxt.rdata = s_r.rword[7:0];
        ADDR_RWORD_HI: s_nxt.rdata = s_r.rword[15:8];
        ADDR_RBYTE:    s_nxt.rdata = s_r.rbyte;
        default:       s_nxt.rdata = 8'h00;
      endcase
    end
    if (core_done) begin
      // (R15) latch result and flag done
      // (R21) left aligned word
      s_nxt.rword = {core_result, RES_PAD};
      // (R18) byte holds top eight
      s_nxt.rbyte = core_result[9:2];
      s_nxt.irq   = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      // (R6) direction all inputs
      // (R19) results cleared
      s_r <= '{dir: DIR_RST, pfunc: PFUNC_RST, cmp_en: 1'b0,
               ctime: CTIME_RST, run: 1'b0, chan: CHAN_RST,
               rword: RWORD_RST, rbyte: RBYTE_RST, rdata: 8'h00,
               bus_wait: 1'b0, irq: 1'b0, abort: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Sub-blocks
  // ==========================================================
  // Decoding is registered so the pin controls come straight from flops;
  // the price is one cycle between a register write and the pins.
  sac_pin_decode u_pin_decode (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .pfunc_i    (s_r.pfunc),
    .dir_i      (s_r.dir),
    .analog_o   (analog_pin_en_o),
    .oe_n_o     (pin_oe_n_o)
  );

  // (R16) run level keeps core going
  sac_sar_core u_sar_core (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .run_i      (s_r.run),
    .restart_i  (s_r.abort),
    .ctime_i    (s_r.ctime),
    .cmp_i      (cmp_result_i),
    .trial_o    (tap_trial_o),
    .sample_o   (sample_hold_o),
    .done_o     (core_done),
    .result_o   (core_result)
  );

  // ==========================================================
  // Outputs
  // ==========================================================
  assign cpu_rdata_o           = s_r.rdata;
  assign cpu_wait_o            = s_r.bus_wait;
  assign comparator_enable_o   = s_r.cmp_en;
  assign channel_selector_o    = s_r.chan;
  assign conversion_done_irq_o = s_r.irq;

  // ==========================================================
  // Checks
  // ==========================================================
  AST_DIR_RESET: assert property (@(posedge core_clk_i)  // (R6)
    srst_i |=> (s_r.dir == DIR_RST && pin_oe_n_o == 8'hFF))
    else $error("Direction register not all ones after reset.");
  AST_PFUNC_READ: assert property (@(posedge core_clk_i)  // (R2)
    disable iff (srst_i)
    (cpu_rd_i && cpu_addr_i == ADDR_PFUNC) |=> (cpu_rdata_o[7:4] == 4'h0))
    else $error("Pin-function upper bits not zero.");
  AST_PFUNC_WAIT: assert property (@(posedge core_clk_i)  // (R3)
    disable iff (srst_i) wr_pfunc |=> cpu_wait_o ##1 !cpu_wait_o || wr_pfunc
    || wr_chan || rd_result)
    else $error("No wait cycle on pin-function write.");
  AST_RESULT_PAIR: assert property (@(posedge core_clk_i)  // (R15)
    disable iff (srst_i) conversion_done_irq_o
    |-> (s_r.rword[15:8] == s_r.rbyte && s_r.rword[5:0] == 6'h00
         && s_r.rword[15:6] == $past(core_result)))
    else $error("Result registers disagree at completion.");
  AST_IRQ_NEEDS_RUN: assert property (@(posedge core_clk_i)  // (R23)
    disable iff (srst_i) conversion_done_irq_o |-> $past(s_r.run, 2))
    else $error("Completion after run was cleared.");
  AST_RESULT_KEEP: assert property (@(posedge core_clk_i)  // (R23)
    disable iff (srst_i) !conversion_done_irq_o |-> $stable(s_r.rword))
    else $error("Result changed without completion.");
  AST_CHAN_ABORT: assert property (@(posedge core_clk_i)  // (R17)
    disable iff (srst_i) (wr_chan && s_r.run && s_nxt.run)
    |=> ##1 (sample_hold_o && !core_done))
    else $error("Channel write did not restart conversion.");

endmodule
`default_nettype wire

// >>> tb/sac_front_model.sv
`timescale 1ns/10ps
`default_nettype none
module sac_front_model import sac_pkg::*; (
  input  wire logic       core_clk_i,
  input  wire logic       enable_i,
  input  wire logic       sample_i,
  input  wire logic [2:0] channel_i,
  input  wire logic [9:0] tap_i,
  output logic            cmp_o
);
  // ==========================================================
  // Input voltages as ideal codes, written by the bench
  // ==========================================================
  logic [9:0] vin [PIN_CNT];
  logic [9:0] held_r;
  logic       noise_r;

  initial begin
    held_r  = 10'h000;
    noise_r = 1'b0;
    for (int k = 0; k < PIN_CNT; k++) begin
      vin[k] = 10'h000;
    end
  end

  always @(posedge core_clk_i) begin
    noise_r <= ~noise_r;
    if (sample_i) begin
      held_r <= vin[channel_i];
    end
  end

  // comparison.
  // An unpowered comparator toggles, so a design using it gets garbage.
  always_comb begin
    cmp_o = enable_i ? (held_r >= tap_i) : noise_r;
  end
endmodule
`default_nettype wire

// >>> tb/sac_adc_ctrl_test.sv
`timescale 1ns/10ps
`default_nettype none
module sac_adc_ctrl_test;
  import sac_pkg::*;
  logic        clk;
  logic        srst;
  logic [15:0] addr;
  logic        wr_s;
  logic        rd_s;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        wt;
  logic        cmp;
  logic        cen;
  logic        smp;
  logic [9:0]  tap;
  logic [2:0]  chan;
  logic [7:0]  aen;
  logic [7:0]  oen;
  logic        irq;
  logic        wait_seen;
  logic [7:0]  rd_val;
  logic [7:0]  am;
  int          fails;
  int          tests_run;
  int          n;
  int          p0;
  int          p1;
  logic [9:0]  codes [5] = '{10'h3FF, 10'h000, 10'h200, 10'h1FF, 10'h155};

  sac_adc_ctrl sac_adc_ctrl_i (
    .core_clk_i(clk), .srst_i(srst), .cpu_addr_i(addr), .cpu_wr_i(wr_s),
    .cpu_rd_i(rd_s), .cpu_wdata_i(wdata), .cpu_rdata_o(rdata),
    .cpu_wait_o(wt), .cmp_result_i(cmp), .comparator_enable_o(cen),
    .sample_hold_o(smp), .tap_trial_o(tap), .channel_selector_o(chan),
    .analog_pin_en_o(aen), .pin_oe_n_o(oen), .conversion_done_irq_o(irq)
  );

  sac_front_model sac_front_model_i (
    .core_clk_i(clk), .enable_i(cen), .sample_i(smp),
    .channel_i(chan), .tap_i(tap), .cmp_o(cmp)
  );

  initial begin
    clk = 1'b0;
    forever begin
      #2 clk = ~clk;
    end
  end

  // ==========================================================
  // Access tasks
  // ==========================================================
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Every access leaves one idle cycle, which also covers the wait cycle.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    addr  = a;
    wdata = d;
    wr_s  = 1'b1;
    @(posedge clk);
    #1 wr_s = 1'b0;
    wait_seen = wt;
    @(posedge clk);
    #1;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    addr = a;
    rd_s = 1'b1;
    @(posedge clk);
    #1 rd_s = 1'b0;
    rd_val = rdata;
    check(16'(rd_val), 16'(exp));
    @(posedge clk);
    #1;
  endtask

  task automatic chk_res(input logic [9:0] v);
    rd_chk(ADDR_RWORD_HI, v[9:2]);
    rd_chk(ADDR_RWORD_LO, {v[1:0], RES_PAD});
    rd_chk(ADDR_RBYTE, v[9:2]);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wait_irq(output int cyc);
    cyc = 0;
    do begin
      @(posedge clk);
      #1 cyc++;
    end while (irq !== 1'b1 && cyc < 2000);
    if (irq !== 1'b1) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
      complete_run();
    end
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    fails     = 0;
    tests_run = 0;
    srst      = 1'b1;
    addr      = 16'h0000;
    wr_s      = 1'b0;
    rd_s      = 1'b0;
    wdata     = 8'h00;
    repeat (10) @(posedge clk);
    #1 srst = 1'b0;
    check(16'(aen), 16'h00FF);
    check(16'(oen), 16'h00FF);
    rd_chk(ADDR_PORT_DIR, DIR_RST);
    rd_chk(ADDR_PFUNC, 8'h00);
    rd_chk(ADDR_CHAN, 8'h00);
    chk_res(10'h000);
    rd_chk(16'hFF30, 8'h00);
    $display("test reset done");

    wr(ADDR_PORT_DIR, 8'h5A);
    rd_chk(ADDR_PORT_DIR, 8'h5A);
    for (int c = 0; c < 10; c++) begin
      wr(ADDR_PFUNC, 8'hF0 | 8'(c));
      check(16'(wait_seen), 16'h0001);
      am = (c > 8) ? 8'hFF : ~((8'h01 << c) - 8'h01);
      check(16'(aen), 16'(am));
      check(16'(oen), 16'(am | 8'h5A));
      rd_chk(ADDR_PFUNC, 8'(c));
    end
    wr(ADDR_PFUNC, PFUNC_ALL_DIG);
    wr(ADDR_PORT_DIR, 8'h00);
    check(16'(oen), 16'h0000);
    wr(ADDR_PORT_DIR, 8'hFF);
    wr(ADDR_PFUNC, 8'h00);
    wr(ADDR_CHAN, 8'hFB);
    rd_chk(ADDR_CHAN, 8'h03);
    check(16'(chan), 16'h0003);
    $display("test pins done");

    wr(ADDR_MODE, 8'h01);
    check(16'(cen), 16'h0001);
    repeat (250) @(posedge clk);
    #1 sac_front_model_i.vin[3] = codes[0];
    wr(ADDR_MODE, 8'h81);
    check(16'(smp), 16'h0001);
    for (int i = 0; i < 5; i++) begin
      wait_irq(n);
      if (i < 4) begin
        sac_front_model_i.vin[3] = codes[i + 1];
      end
      chk_res(codes[i]);
    end
    $display("test convert done");

    // The channel write lands mid conversion of the old channel.
    sac_front_model_i.vin[5] = 10'h2A5;
    repeat (40) @(posedge clk);
    #1 wr(ADDR_CHAN, 8'h05);
    wait_irq(n);
    chk_res(10'h2A5);
    wait_irq(p0);
    // stop before changing the conversion time.
    wr(ADDR_MODE, 8'h01);
    wr(ADDR_MODE, 8'hB9);
    wait_irq(n);
    wait_irq(p1);
    // The first gap starts after six read cycles, the second at completion.
    check(16'(p1 - p0), 16'h004C);
    $display("test restart done");

    sac_front_model_i.vin[5] = 10'h0F0;
    repeat (50) @(posedge clk);
    #1 wr(ADDR_MODE, 8'h01);
    check(16'(smp), 16'h0000);
    n = 0;
    repeat (300) begin
      @(posedge clk);
      #1 n += int'(irq === 1'b1);
    end
    check(16'(n), 16'h0000);
    chk_res(10'h2A5);
    wr(ADDR_MODE, 8'h81);
    wait_irq(n);
    chk_res(10'h0F0);
    wr(ADDR_MODE, 8'h00);
    check(16'(cen), 16'h0000);
    $display("test stop done");
    complete_run();
  end
endmodule
`default_nettype wire
